// >>> design/xrl_pkg.sv
package xrl_pkg;

    localparam int NUM_OUT  = 16;
    localparam int NUM_IN   = 16;
    localparam int FIELD_W  = 5;
    localparam int SR_W     = NUM_OUT * FIELD_W;
    localparam int SEL_W    = 4;
    localparam int ON_POS   = 4;

    // One output field: enable on top, input number below
    typedef struct packed {
        logic             on;
        logic [SEL_W-1:0] in_sel;
    } xrl_field_t;

    // Host pins, as sampled
    typedef struct packed {
        logic             host_clk;
        logic             data_in;
        logic             cs_n;
        logic             update_n;
        logic             mode;
        logic [SEL_W-1:0] out_sel;
        xrl_field_t       pdata;
    } xrl_pins_t;

    localparam xrl_pins_t PINS_RST = '{host_clk: 1'b1, data_in: 1'b0, cs_n: 1'b1, update_n: 1'b1,
                                       mode: 1'b0, out_sel: 4'h0, pdata: 5'h00};
    localparam logic      MODE_SER = 1'b0;

endpackage

// >>> design/xrl_route_loader.sv
// Function
// - Chip select high: clock, data and update ignored, logic unchanged.
// - Shift register acts only on falling edge of host clock.
// - Mode select low means serial load, high means parallel load.
// - Serial mode: each edge shifts data in; first bit exits 80 clocks later.
// - Parallel mode: each edge writes five data lines into addressed 5-bit field.
// - Chip select and update both low: latches follow shift register.
// - Update high: latches hold, routing undisturbed by shifting.
// - Reset low disables all outputs asynchronously and resets the pin synchronisers; other state kept.
// - Four address lines form output number, first line least significant.
// - Low four field bits form input number, first data line least significant.
// - Fifth field bit enables output when set, disables when clear.
// - Decoder turns on exactly one input stage per output, none if disabled.
// - Serial output allows daisy chaining of several devices.
`timescale 1ns/100ps
module xrl_route_loader
    import xrl_pkg::*;
(
    input  wire logic                            mclk,
    input  wire logic                            arst_n,
    input  wire logic                            host_clk,
    input  wire logic                            data_in,
    input  wire logic                            cs_n,
    input  wire logic                            update_n,
    input  wire logic                            load_mode_select,
    input  wire logic [SEL_W-1:0]                out_sel,
    input  wire logic [SEL_W-1:0]                in_sel_data,
    input  wire logic                            output_on_bit,
    output logic                                 serial_out,
    output logic [NUM_OUT-1:0]                   out_enable,
    output logic [NUM_OUT-1:0][NUM_IN-1:0]       stage_on
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    xrl_pins_t              pins_raw;
    xrl_pins_t              sync1_r;
    xrl_pins_t              sync2_r;
    logic                   clk_prev_r;
    logic                   clk_prev_nxt;
    logic                   fall;
    logic                   active;

    // Every pin goes through the same two stages, so the data, address and
    // mode bits seen with a detected fall are those set up before it; the
    // host keeps them steady for a few system clocks around each fall.
    always_comb begin
        pins_raw          = PINS_RST;
        pins_raw.host_clk = host_clk;
        pins_raw.data_in  = data_in;
        pins_raw.cs_n     = cs_n;
        pins_raw.update_n = update_n;
        pins_raw.mode     = load_mode_select;
        pins_raw.out_sel  = out_sel;
        pins_raw.pdata    = '{on: output_on_bit, in_sel: in_sel_data};
        clk_prev_nxt      = sync2_r.host_clk;
    end

    // The stages reset to the idle pin levels, so no false fall and no
    // chip select is seen as reset ends.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r    <= PINS_RST;
            sync2_r    <= PINS_RST;
            clk_prev_r <= 1'b1;
        end else begin
            sync1_r    <= pins_raw;
            sync2_r    <= sync1_r;
            clk_prev_r <= clk_prev_nxt;
        end
    end

    // A fall is a high-to-low step between two synchronised samples; each
    // host clock phase must last more than one system clock to be seen.
    assign fall   = clk_prev_r & ~sync2_r.host_clk;
    assign active = ~sync2_r.cs_n & sync2_r.update_n;

    // ------------------------------------------------------------
    // First rank and second rank
    // ------------------------------------------------------------
    // Neither rank is reset: reset only gates the switch array.
    logic [SR_W-1:0]        sr_r;
    logic [SR_W-1:0]        sr_nxt;
    logic [SR_W-1:0]        latch_r;
    logic [SR_W-1:0]        latch_nxt;
    logic                   route_known_r;
    logic                   route_known_nxt;
    logic                   latch_open;
    logic [SR_W-1:0]        par_mask;

    // Latches are transparent while the chip is selected and update is low
    assign latch_open = ~sync2_r.cs_n & ~sync2_r.update_n;

    // Bits that a parallel write is allowed to touch
    assign par_mask = SR_W'({FIELD_W{1'b1}}) << (sync2_r.out_sel * FIELD_W);

    // Both ranks are unknown from power-up until the host loads them.
    // route_known_r is set once the latches have copied a load, so the
    // decoder checks wait on it. Like the ranks it has no reset, so a
    // reset does not hide the routing that the latches still hold.
    always_comb begin
        sr_nxt          = sr_r;
        latch_nxt       = latch_r;
        route_known_nxt = route_known_r | latch_open;
        if (fall && active) begin
            if (sync2_r.mode == MODE_SER) begin
                sr_nxt = {sr_r[SR_W-2:0], sync2_r.data_in};
            end else begin
                sr_nxt[sync2_r.out_sel*FIELD_W +: FIELD_W] = sync2_r.pdata;
            end
        end
        if (latch_open) begin
            latch_nxt = sr_r;
        end
    end

    always_ff @(posedge mclk) begin
        sr_r    <= sr_nxt;
        latch_r       <= latch_nxt;
        route_known_r <= route_known_nxt;
    end

    // Shift register top bit; meaningless in parallel mode
    assign serial_out = sr_r[SR_W-1];

    // ------------------------------------------------------------
    // Per-output decoder
    // ------------------------------------------------------------
    // Reset gates the enables directly, so the outputs drop without a clock
    for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
        xrl_field_t fld;
        assign fld           = latch_r[o*FIELD_W +: FIELD_W];
        assign out_enable[o] = fld.on & arst_n;
        for (genvar i = 0; i < NUM_IN; i++) begin : g_in
            assign stage_on[o][i] = out_enable[o] & (fld.in_sel == SEL_W'(i));
        end

        // Decoder checks wait until the latches hold a real load
        chk_decode_onehot: assert property (@(posedge mclk) disable iff (!arst_n)
            route_known_r |->
                (stage_on[o] == (latch_r[o*FIELD_W+ON_POS] ? (16'h0001 << latch_r[o*FIELD_W +: SEL_W]) : 16'h0000)))
            else $error("decoder output does not match latched field");

        chk_stage_single: assert property (@(posedge mclk) disable iff (!arst_n)
            route_known_r |-> $onehot0(stage_on[o]))
            else $error("more than one input stage on for an output");

        chk_enable_follow: assert property (@(posedge mclk) disable iff (!arst_n)
            route_known_r |-> (out_enable[o] == latch_r[o*FIELD_W+ON_POS]))
            else $error("output enable does not follow its latched bit");

        chk_off_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
            (route_known_r && !latch_r[o*FIELD_W+ON_POS]) |-> (stage_on[o] == '0))
            else $error("disabled output still has an input stage on");
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_cs_freeze: assert property (@(posedge mclk) disable iff (!arst_n)
        sync2_r.cs_n |=> ($stable(sr_r) && $stable(latch_r)))
        else $error("logic changed while chip select high");

    chk_edge_only: assert property (@(posedge mclk) disable iff (!arst_n)
        !fall |=> $stable(sr_r))
        else $error("shift register changed without falling edge");

    chk_serial_shift: assert property (@(posedge mclk) disable iff (!arst_n)
        (fall && active && !sync2_r.mode) |=>
            (sr_r === {$past(sr_r[SR_W-2:0]), $past(sync2_r.data_in)}))
        else $error("serial shift wrong");

    chk_par_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (fall && active && sync2_r.mode) |=>
            (sr_r[$past(sync2_r.out_sel)*FIELD_W +: FIELD_W] == $past(sync2_r.pdata)))
        else $error("parallel field write wrong");

    chk_latch_follow: assert property (@(posedge mclk) disable iff (!arst_n)
        (!sync2_r.cs_n && !sync2_r.update_n) |=> (latch_r == $past(sr_r)))
        else $error("latches not transparent");

    chk_latch_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        sync2_r.update_n |=> $stable(latch_r))
        else $error("latches changed while update high");

    chk_reset_off: assert property (@(posedge mclk)
        !arst_n |-> (out_enable == '0 && stage_on == '0))
        else $error("outputs enabled during reset");

    chk_daisy_out: assert property (@(posedge mclk) disable iff (!arst_n)
        (fall && active && !sync2_r.mode) |=> (serial_out === $past(sr_r[SR_W-2])))
        else $error("serial output not shifted");

    // ------------------------------------------------------------
    // Checks: blocked writes, reset and held routing
    // ------------------------------------------------------------
    // Reset gates only the outputs; both ranks and the serial output
    // must come through a reset untouched.
    chk_update_blocks: assert property (@(posedge mclk) disable iff (!arst_n)
        !sync2_r.update_n |=> $stable(sr_r))
        else $error("shift register changed while update low");

    chk_par_others: assert property (@(posedge mclk) disable iff (!arst_n)
        (fall && active && sync2_r.mode) |=>
            (((sr_r ^ $past(sr_r)) & ~$past(par_mask)) == '0))
        else $error("parallel write touched another field");

    chk_cs_serial: assert property (@(posedge mclk) disable iff (!arst_n)
        sync2_r.cs_n |=> $stable(serial_out))
        else $error("serial output changed while chip select high");

    chk_reset_keep: assert property (@(posedge mclk)
        !arst_n |=> ($stable(sr_r) && $stable(latch_r)))
        else $error("reset disturbed the ranks");

    chk_route_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        (route_known_r && sync2_r.update_n) |=> ($stable(out_enable) && $stable(stage_on)))
        else $error("routing changed while update high");

endmodule

// >>> dv/xrl_host_model.sv
`timescale 1ns/100ps
module xrl_host_model
    import xrl_pkg::*;
(
    input  wire logic mclk,
    output logic      host_clk,
    output logic      data_in,
    output logic      cs_n,
    output logic      update_n,
    output logic      mode,
    output logic [3:0] out_sel,
    output xrl_field_t pdata
);
    initial begin
        {host_clk, data_in, cs_n, update_n, mode, out_sel, pdata} = PINS_RST;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Pins settle, clock falls, pins held past the fall
    task automatic pulse(input logic cs, input logic md, input logic d, input logic [3:0] a, input xrl_field_t f);
        cs_n = cs;
        mode = md;
        data_in = d;
        out_sel = a;
        pdata = f;
        wait_clk(4);
        host_clk = 1'b0;
        wait_clk(4);
        host_clk = 1'b1;
        data_in = ~d;
        wait_clk(1);
    endtask
    // Update strobe low long enough for the latches to copy
    task automatic upd(input logic cs);
        cs_n = cs;
        update_n = 1'b0;
        wait_clk(4);
        update_n = 1'b1;
        wait_clk(4);
    endtask
endmodule

// >>> dv/xrl_route_loader_bench.sv
`timescale 1ns/100ps
module xrl_route_loader_bench;
    import xrl_pkg::*;
    logic mclk, arst_n, host_clk, data_in, cs_n, update_n, mode, serial_out;
    logic [3:0] out_sel;
    logic [3:0] a;
    xrl_field_t pdata, f;
    xrl_field_t sr_f [NUM_OUT];
    xrl_field_t lat_f [NUM_OUT];
    logic [NUM_OUT-1:0] out_enable;
    logic [NUM_OUT-1:0][NUM_IN-1:0] stage_on;
    logic [31:0] lfsr = 32'h0001_62dd;
    logic bits_q [$];
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    xrl_host_model u_host (.mclk(mclk), .host_clk(host_clk), .data_in(data_in), .cs_n(cs_n),
        .update_n(update_n), .mode(mode), .out_sel(out_sel), .pdata(pdata));
    xrl_route_loader i_dut (.mclk(mclk), .arst_n(arst_n), .host_clk(host_clk), .data_in(data_in),
        .cs_n(cs_n), .update_n(update_n), .load_mode_select(mode), .out_sel(out_sel),
        .in_sel_data(pdata.in_sel), .output_on_bit(pdata.on), .serial_out(serial_out),
        .out_enable(out_enable), .stage_on(stage_on));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [NUM_OUT*(NUM_IN+1)-1:0] route_exp(input logic gated);
        logic [NUM_OUT-1:0] en;
        logic [NUM_OUT-1:0][NUM_IN-1:0] st;
        en = '0;
        st = '0;
        for (int o = 0; o < NUM_OUT; o++) begin
            en[o] = lat_f[o].on & ~gated;
            if (en[o]) st[o][lat_f[o].in_sel] = 1'b1;
        end
        return {en, st};
    endfunction
    task automatic report(input logic [271:0] got, input logic [271:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_route(input logic gated);
        report({out_enable, stage_on}, route_exp(gated));
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        report(272'(got), 272'(exp));
    endtask
    task automatic serial_load();
        for (int o = NUM_OUT-1; o >= 0; o--) begin
            lfsr = nx(lfsr);
            sr_f[o] = lfsr[4:0];
            for (int b = FIELD_W-1; b >= 0; b--) begin
                u_host.pulse(1'b0, MODE_SER, sr_f[o][b], lfsr[8:5], lfsr[13:9]);
                bits_q.push_back(sr_f[o][b]);
                if (bits_q.size() >= SR_W) chk_bit(serial_out, bits_q[$-(SR_W-1)]);
            end
        end
    endtask
    task automatic apply(input logic cs);
        u_host.upd(cs);
        if (!cs) lat_f = sr_f;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        arst_n = 1'b0;
        repeat (20) @(posedge mclk);
        #1 arst_n = 1'b1;
        serial_load();
        apply(1'b0);
        chk_route(1'b0);
        serial_load();
        chk_route(1'b0);
        apply(1'b0);
        chk_route(1'b0);
        for (int i = 0; i < 24; i++) begin
            lfsr = nx(lfsr);
            a = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : lfsr[3:0];
            f = lfsr[8:4];
            u_host.pulse(1'b0, 1'b1, lfsr[9], a, f);
            sr_f[a] = f;
        end
        apply(1'b0);
        chk_route(1'b0);
        for (int i = 0; i < 8; i++) begin
            lfsr = nx(lfsr);
            u_host.pulse(1'b1, lfsr[0], lfsr[1], lfsr[5:2], lfsr[10:6]);
        end
        apply(1'b1);
        chk_route(1'b0);
        apply(1'b0);
        chk_route(1'b0);
        arst_n = 1'b0;
        #2 chk_route(1'b1);
        repeat (3) @(posedge mclk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk_route(1'b0);
        stop_test();
    end
endmodule
